// ===== logic/sdsr_status_regs.sv
// Purpose: Read-only diagnostic status bank of a stepper motor driver
// Assumes: Serial framing and parity generation sit outside this block
// Notes: Read data is registered one cycle after the read strobe
// Notes: Latched flags clear on a read only once their fault has gone
// Notes: Detector levels pass two flip-flops before any logic sees them
module sdsr_status_regs (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire sdsr_pkg::sdsr_faults_s fault_in,
  input wire logic [6:0] microstep_position,
  input wire sdsr_pkg::sdsr_read_s read_req,
  input wire logic parity_bit,
  output logic [7:0] read_data,
  output logic read_valid,
  output logic [3:0] x_fault_out,
  output logic [4:0] y_fault_out
);
  // Detector levels after the synchroniser
  sdsr_pkg::sdsr_faults_s fault_sync;

  // Named bridge levels, one per transistor, plus the thermal shutdown level
  logic x_pos_top_overcurrent;
  logic x_pos_bottom_overcurrent;
  logic x_neg_top_overcurrent;
  logic x_neg_bottom_overcurrent;
  logic y_pos_top_overcurrent;
  logic y_pos_bottom_overcurrent;
  logic y_neg_top_overcurrent;
  logic y_neg_bottom_overcurrent;
  logic thermal_shutdown_flag;

  // Live bits of the general register
  logic warn_live;
  logic pump_live;
  logic x_open_live;
  logic y_open_live;

  // Raw levels in register order
  logic [3:0] x_raw;
  logic [4:0] y_raw;

  // Sticky flag state
  logic [3:0] x_latch_reg;
  logic [3:0] x_latch_next;
  logic [4:0] y_latch_reg;
  logic [4:0] y_latch_next;

  // Read decode per latched register
  logic rd_x;
  logic rd_y;

  // Latched flags merged with the live level
  logic [3:0] x_view;
  logic [4:0] y_view;

  // Register images before parity is merged
  logic [7:0] general_byte;
  logic [7:0] x_byte;
  logic [7:0] y_byte;
  logic [7:0] position_byte;
  logic [7:0] selected_byte;

  // Registered answer
  logic [7:0] read_data_reg;
  logic [7:0] read_data_next;
  logic read_valid_reg;
  logic read_valid_next;

  // Detector levels come from the analog side, so two flops first
  sdsr_sync #(
    .WIDTH(sdsr_pkg::SYNC_WIDTH)
  ) u_fault_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in(fault_in),
    .sync_out(fault_sync)
  );

  // Split the bridge flags out of the synchronised bundle
  assign x_pos_top_overcurrent = fault_sync.x_ovc[3];
  assign x_pos_bottom_overcurrent = fault_sync.x_ovc[2];
  assign x_neg_top_overcurrent = fault_sync.x_ovc[1];
  assign x_neg_bottom_overcurrent = fault_sync.x_ovc[0];
  assign y_pos_top_overcurrent = fault_sync.y_ovc[3];
  assign y_pos_bottom_overcurrent = fault_sync.y_ovc[2];
  assign y_neg_top_overcurrent = fault_sync.y_ovc[1];
  assign y_neg_bottom_overcurrent = fault_sync.y_ovc[0];
  assign thermal_shutdown_flag = fault_sync.thermal_shutdown_flag;

  // Live general status levels, never held
  assign warn_live = fault_sync.thermal_warning_flag;
  assign pump_live = fault_sync.charge_pump_fail;
  assign x_open_live = fault_sync.x_open_coil_flag;
  assign y_open_live = fault_sync.y_open_coil_flag;

  // Order: pos_top, pos_bottom, neg_top, neg_bottom, then shutdown
  assign x_raw = {x_pos_top_overcurrent, x_pos_bottom_overcurrent,
    x_neg_top_overcurrent, x_neg_bottom_overcurrent};
  assign y_raw = {y_pos_top_overcurrent, y_pos_bottom_overcurrent,
    y_neg_top_overcurrent, y_neg_bottom_overcurrent,
    thermal_shutdown_flag};

  // A read of 05h or 06h is what clears vanished faults
  assign rd_x = read_req.rd_en && (read_req.addr == sdsr_pkg::ADDR_X_FAULT);
  assign rd_y = read_req.rd_en && (read_req.addr == sdsr_pkg::ADDR_Y_FAULT);

  // Host sees latched flags plus any fault present right now
  assign x_view = x_latch_reg | x_raw;
  assign y_view = y_latch_reg | y_raw;

  // Sticky flags: a set wins over the clear of the same cycle
  always_comb begin
    x_latch_next = x_view;
    y_latch_next = y_view;
    if (rd_x) begin
      x_latch_next = x_raw;
    end
    if (rd_y) begin
      y_latch_next = y_raw;
    end
  end

  // Sticky flag registers, cleared by reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      x_latch_reg <= '0;
      y_latch_reg <= '0;
    end else begin
      x_latch_reg <= x_latch_next;
      y_latch_reg <= y_latch_next;
    end
  end

  // General register image, flag bits live, bits 4, 1 and 0 stay zero
  always_comb begin
    general_byte = sdsr_pkg::STATUS_RESET;
    general_byte[sdsr_pkg::TW_BIT] = warn_live;
    general_byte[sdsr_pkg::CP_BIT] = pump_live;
    general_byte[sdsr_pkg::X_OPEN_COIL_FLAG_BIT] = x_open_live;
    general_byte[sdsr_pkg::Y_OPEN_COIL_FLAG_BIT] = y_open_live;
  end

  // X fault image, unused low bits stay zero
  always_comb begin
    x_byte = sdsr_pkg::STATUS_RESET;
    x_byte[sdsr_pkg::OVC_MSB:sdsr_pkg::OVC_LSB] = x_view;
  end

  // Y fault image with shutdown just below the flags
  always_comb begin
    y_byte = sdsr_pkg::STATUS_RESET;
    y_byte[sdsr_pkg::OVC_MSB:sdsr_pkg::TSD_BIT] = y_view;
  end

  // Position image, the translator value passes unheld
  always_comb begin
    position_byte = sdsr_pkg::STATUS_RESET;
    position_byte[sdsr_pkg::PARITY_BIT-1:0] = microstep_position;
  end

  // Address decode, unknown addresses read as zero
  always_comb begin
    case (read_req.addr)
      sdsr_pkg::ADDR_GENERAL: begin
        selected_byte = general_byte;
      end
      sdsr_pkg::ADDR_X_FAULT: begin
        selected_byte = x_byte;
      end
      sdsr_pkg::ADDR_Y_FAULT: begin
        selected_byte = y_byte;
      end
      sdsr_pkg::ADDR_POSITION: begin
        selected_byte = position_byte;
      end
      default: begin
        selected_byte = sdsr_pkg::STATUS_RESET;
      end
    endcase
  end

  // Answer path: parity on top, byte held between reads
  always_comb begin
    read_data_next = read_data_reg;
    read_valid_next = read_req.rd_en;
    if (read_req.rd_en) begin
      read_data_next = selected_byte;
      read_data_next[sdsr_pkg::PARITY_BIT] = parity_bit;
    end
  end

  // Answer registers, no write path exists
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_data_reg <= sdsr_pkg::STATUS_RESET;
      read_valid_reg <= 1'b0;
    end else begin
      read_data_reg <= read_data_next;
      read_valid_reg <= read_valid_next;
    end
  end

  // Every output straight from a flop
  assign read_data = read_data_reg;
  assign read_valid = read_valid_reg;
  assign x_fault_out = x_latch_reg;
  assign y_fault_out = y_latch_reg;
endmodule // sdsr_status_regs

// ===== pkg/sdsr_pkg.sv
// Purpose: Shared constants and carriers for the motor driver status bank
// Assumes: One 25 MHz clock, register reads arrive as a read strobe
// Notes: Offsets are the documented status register addresses
package sdsr_pkg;
  localparam logic [2:0] ADDR_GENERAL = 3'h4;
  localparam logic [2:0] ADDR_X_FAULT = 3'h5;
  localparam logic [2:0] ADDR_Y_FAULT = 3'h6;
  localparam logic [2:0] ADDR_POSITION = 3'h7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [6:0] POSITION_RESET = 7'h00;
  localparam int PARITY_BIT = 7;
  localparam int TW_BIT = 6;
  localparam int CP_BIT = 5;
  localparam int X_OPEN_COIL_FLAG_BIT = 3;
  localparam int Y_OPEN_COIL_FLAG_BIT = 2;
  localparam int OVC_MSB = 6;
  localparam int OVC_LSB = 3;
  localparam int TSD_BIT = 2;
  localparam int SYNC_WIDTH = 15; // Bits in sdsr_faults_s

  // Raw fault inputs from the analog detectors
  typedef struct packed {
    logic thermal_warning_flag;
    logic charge_pump_fail;
    logic x_open_coil_flag;
    logic y_open_coil_flag;
    logic [3:0] x_ovc;    // pos_top, pos_bottom, neg_top, neg_bottom
    logic [3:0] y_ovc;    // same order
    logic thermal_shutdown_flag;
    logic [1:0] pad;
  } sdsr_faults_s;

  // Register read request
  typedef struct packed {
    logic rd_en;
    logic [2:0] addr;
  } sdsr_read_s;
endpackage : sdsr_pkg

// ===== logic/sdsr_sync.sv
// Purpose: Two flip-flop synchroniser for a bundle of levels
// Assumes: Inputs are asynchronous levels
// Notes: First stage is read only by the second stage
module sdsr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // Two-stage capture
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule // sdsr_sync

// ===== testbench/sdsr_monitor.sv
// Purpose: Port assertions for the status bank
// Assumes: Reads answer one cycle after the strobe
// Notes: Bound into every status bank instance
module sdsr_monitor (
  input logic ref_clk,
  input logic reset_n,
  input logic [6:0] microstep_position,
  input sdsr_pkg::sdsr_read_s read_req,
  input logic parity_bit,
  input logic [7:0] read_data,
  input logic read_valid,
  input logic [3:0] x_fault_out,
  input logic [4:0] y_fault_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Strobes decoded per address
  wire r5 = read_req.rd_en && read_req.addr == 3'h5;
  wire r6 = read_req.rd_en && read_req.addr == 3'h6;
  wire r7 = read_req.rd_en && read_req.addr == 3'h7;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_v; read_req.rd_en |=> read_valid; endproperty
  property p_p; read_req.rd_en |=> read_data[7] == $past(parity_bit);
  endproperty
  property p_m; r7 |=> read_data[6:0] == $past(microstep_position);
  endproperty
  property p_g; read_req.rd_en && read_req.addr == 3'h4 |=>
    read_data[4] == 1'b0 && read_data[1:0] == 2'h0; endproperty
  property p_x; r5 |=> read_data[2:0] == 3'h0 &&
    (read_data[6:3] | ~$past(x_fault_out)) == 4'hF; endproperty
  property p_y; r6 |=> read_data[1:0] == 2'h0 &&
    (read_data[6:2] | ~$past(y_fault_out)) == 5'h1F; endproperty
  property p_lx; !r5 |=> (x_fault_out | ~$past(x_fault_out)) == 4'hF;
  endproperty
  property p_ly; !r6 |=> (y_fault_out | ~$past(y_fault_out)) == 5'h1F;
  endproperty
  a_v: assert property (p_v) else $error("no valid");
  a_p: assert property (p_p) else $error("parity");
  a_m: assert property (p_m) else $error("position");
  a_g: assert property (p_g) else $error("general");
  a_x: assert property (p_x) else $error("x read");
  a_y: assert property (p_y) else $error("y read");
  a_lx: assert property (p_lx) else $error("x latch");
  a_ly: assert property (p_ly) else $error("y latch");
  cover property (r5 ##1 read_data[6]);
  cover property (r7 ##1 read_data[0]);
  cover property ($fell(|y_fault_out));
endmodule // sdsr_monitor
bind sdsr_status_regs sdsr_monitor i_mon (.*);

// ===== testbench/sdsr_host.sv
// Purpose: Host model issuing status reads
// Assumes: Parity is the XOR of the address
// Notes: Waits at most four cycles for an answer
module sdsr_host (
  input logic ref_clk,
  input logic [7:0] read_data,
  input logic read_valid,
  output sdsr_pkg::sdsr_read_s read_req = '0,
  output logic parity_bit = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // One strobe, then a bounded wait for valid
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    @(posedge ref_clk);
    read_req <= '{1'b1, a};
    parity_bit <= ^a;
    @(posedge ref_clk);
    read_req <= '0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1 ok = read_valid;
      d = read_data;
      if (!ok) @(posedge ref_clk);
    end
  endtask
endmodule // sdsr_host

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the status bank
// Assumes: Host model reads, bench drives faults
// Notes: Faults settle within four cycles
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [6:0] msp = 7'h00;
  sdsr_pkg::sdsr_faults_s flt = '0;
  sdsr_pkg::sdsr_read_s rq;
  logic par, rv;
  logic [7:0] rdat;
  logic [3:0] xf;
  logic [4:0] yf;
  int bad_count = 0;
  int n_compared = 0;
  sdsr_status_regs i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .fault_in(flt), .microstep_position(msp), .read_req(rq),
    .parity_bit(par), .read_data(rdat), .read_valid(rv),
    .x_fault_out(xf), .y_fault_out(yf));
  sdsr_host i_host (.ref_clk(ref_clk), .read_data(rdat), .read_valid(rv),
    .read_req(rq), .parity_bit(par));
  task tally_and_finish;
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t %h %h", $time, s, e);
    end
  endtask
  // One read, judged against the expected byte
  task rc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit ok;
    i_host.rd(a, d, ok);
    if (!ok) begin
      bad_count++;
      tally_and_finish;
    end else chk(d, e);
  endtask
  task t_live;
    @(posedge ref_clk);
    flt <= 15'h6800;
    msp <= 7'h55;
    repeat (4) @(posedge ref_clk);
    rc(3'h4, 8'hE4);
    rc(3'h7, 8'hD5);
    @(posedge ref_clk);
    flt <= 15'h1000;
    msp <= 7'h2A;
    repeat (4) @(posedge ref_clk);
    rc(3'h4, 8'h88);
    rc(3'h7, 8'hAA);
  endtask
  task t_latch;
    @(posedge ref_clk);
    flt <= 15'h052C;
    repeat (4) @(posedge ref_clk);
    flt <= '0;
    repeat (4) @(posedge ref_clk);
    chk({4'h0, xf}, 8'h0A);
    chk({3'h0, yf}, 8'h0B);
    rc(3'h5, 8'h50);
    rc(3'h5, 8'h00);
    rc(3'h6, 8'h2C);
    rc(3'h6, 8'h00);
  endtask
  // Every address reads zero apart from parity after power-on
  task t_idle;
    for (int a = 0; a < 8; a++) begin
      rc(3'(a), {^3'(a), 7'h00});
    end
  endtask
  // Fault still present at the read keeps its flag
  task t_hold;
    @(posedge ref_clk);
    flt <= 15'h0440;
    repeat (4) @(posedge ref_clk);
    rc(3'h5, 8'h40);
    rc(3'h6, 8'h40);
    @(posedge ref_clk);
    flt <= '0;
    repeat (4) @(posedge ref_clk);
    chk({4'h0, xf}, 8'h08);
    chk({3'h0, yf}, 8'h10);
    rc(3'h6, 8'h40);
    rc(3'h6, 8'h00);
  endtask
  // Mid-run hard reset wipes latched flags and the answer
  task t_reset;
    @(posedge ref_clk);
    flt <= 15'h052C;
    repeat (4) @(posedge ref_clk);
    rc(3'h7, 8'hAA);
    @(posedge ref_clk);
    flt <= '0;
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({4'h0, xf}, 8'h00);
    chk({3'h0, yf}, 8'h00);
    chk(rdat, 8'h00);
    reset_n <= 1'b1;
    rc(3'h5, 8'h00);
    rc(3'h6, 8'h00);
  endtask
  // Clock and main sequence
  initial forever #20 ref_clk = ~ref_clk;
  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_idle;
    t_live;
    t_latch;
    t_hold;
    t_reset;
    tally_and_finish;
  end
endmodule // tb
